// ===== core/align_crc_gen.v
`timescale 1ns/1ps
`default_nettype none
`include "link_partner_defs.vh"

module align_crc_gen (
    input wire clk,
    input wire arst_n,
    input wire crcEnable,
    input wire seqStart,
    input wire seqValid,
    input wire [7:0] seqByte,
    output reg outValid,
    output reg [7:0] outByte,
    output reg outIsCrc
);
    reg [7:0] crc;
    reg [3:0] byteIdx;
    reg crcPending;
    reg crcEnLatched;

    function [7:0] crc8Step;
        input [7:0] c;
        input [7:0] d;
        integer i;
        reg [7:0] r;
        begin
            r = c ^ d;
            for (i = 0; i < 8; i = i + 1) begin
                r = r[7] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
            end
            crc8Step = r;
        end
    endfunction

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            crc <= `CRC_INIT;
            byteIdx <= 4'h0;
            crcPending <= 1'b0;
            crcEnLatched <= 1'b0;
            outValid <= 1'b0;
            outByte <= 8'h00;
            outIsCrc <= 1'b0;
        end else begin
            outValid <= 1'b0;
            outIsCrc <= 1'b0;
            if (crcPending) begin
                // ninth byte
                outValid <= 1'b1;
                outByte <= crc;
                outIsCrc <= 1'b1;
                crcPending <= 1'b0;
            end else if (seqValid) begin
                outValid <= 1'b1;
                outByte <= seqByte;
                if (seqStart) begin
                    // enable sampled per sequence so a change mid-sequence cannot cut it
                    crcEnLatched <= crcEnable;
                    crc <= crc8Step(`CRC_INIT, seqByte);
                    byteIdx <= 4'h1;
                end else if (byteIdx < `ALIGN_DATA_BYTES) begin
                    crc <= crc8Step(crc, seqByte);
                    byteIdx <= byteIdx + 4'h1;
                    if (byteIdx == `ALIGN_LAST_IDX && crcEnLatched)
                        crcPending <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== core/link_partner_config_regs.v
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
`include "link_partner_defs.vh"

// Contract
// - crc enable set (reset default) appends crc to each alignment sequence
// - crc covers first eight sequence bytes, sent as the ninth byte
// - two-bit code forwards 0, 1, 2 or 4 gpios
// - capability freeze blocks back-channel load; software values in three registers stay
// - self-test request bit shows partner asks for built-in self-test
// - on back-channel link, self-test, multiport and port number load automatically
// - multiport flag 0 for single-port, 1 for multi-port partner
// - four-bit port number of partner deserializer port
// - seven-bit partner address in bits 7:1, loaded from back channel
// - address freeze in bit 0 stops address auto-load
// - alias match replaces address with target physical address before forwarding
module link_partner_config_regs (
    input wire clk,
    input wire arst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [9:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire backLinkUp,
    input wire capLoadValid,
    input wire capLoadSelftest,
    input wire capLoadMultiport,
    input wire [3:0] capLoadPort,
    input wire [15:0] capLoadExtra,
    input wire addrLoadValid,
    input wire [6:0] addrLoadValue,
    input wire i2cInValid,
    input wire [7:0] i2cInByte,
    input wire i2cInFirst,
    output reg i2cOutValid,
    output reg [7:0] i2cOutByte,
    output reg i2cOutFirst,
    output reg i2cOutRemapped,
    input wire alignStart,
    input wire alignValid,
    input wire [7:0] alignByte,
    output reg alignOutValid,
    output reg [7:0] alignOutByte,
    output reg alignOutIsCrc,
    input wire [3:0] gpioIn,
    output reg [3:0] gpioFwdEnable,
    output reg [3:0] gpioFwdData
);
    reg [7:0] datapathCtl;
    reg [7:0] rsvd34;
    reg [7:0] partnerCap;
    reg [7:0] rsvd36;
    reg [7:0] partnerAddr;
    reg [7:0] rsvd38;
    reg [6:0] targetZero;
    reg [6:0] targetOne;
    reg [7:0] capLow;
    reg [7:0] capHigh;
    reg [6:0] aliasZero;
    reg [6:0] aliasOne;
    reg [2:0] linkSync;
    reg linkUp;
    reg [7:0] next_rdata;
    reg [7:0] next_i2c;
    reg next_remap;
    wire access;
    wire wrEn;
    wire rdEn;
    wire [7:0] regIdx;
    wire [7:0] wrByte;
    wire capFrozen;
    wire addrFrozen;
    wire capAutoLoad;
    wire addrAutoLoad;
    wire alignValidOut;
    wire [7:0] alignByteOut;
    wire alignCrcOut;
    wire [3:0] gpioSel;

    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrEn = access && wb_we_i && wb_sel_i[0];
    assign rdEn = access && !wb_we_i;
    assign regIdx = wb_adr_i[9:2];
    assign wrByte = wb_dat_i[7:0];
    assign capFrozen = partnerCap[`CAP_FREEZE_BIT];
    assign addrFrozen = partnerAddr[`ADDR_FREEZE_BIT];
    // software write in the same cycle wins over a back-channel load
    assign capAutoLoad = linkUp && capLoadValid && !capFrozen;
    assign addrAutoLoad = linkUp && addrLoadValid && !addrFrozen;

    function [3:0] gpioMask;
        input [1:0] code;
        begin
            case (code)
                2'b00: gpioMask = 4'h0;
                2'b01: gpioMask = 4'h1;
                2'b10: gpioMask = 4'h3;
                default: gpioMask = 4'hf;
            endcase
        end
    endfunction

    function regHit;
        input en;
        input [7:0] idx;
        input [7:0] want;
        begin
            regHit = en && (idx == want);
        end
    endfunction

    // an all-zero entry is treated as unset, so it can never claim a transfer
    function entryHit;
        input [6:0] entry;
        input [6:0] addr;
        begin
            entryHit = (entry != 7'h00) && (addr == entry);
        end
    endfunction

    // link level comes from the partner's domain; three stages, change on 2nd/3rd agreement
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            linkSync <= 3'b000;
            linkUp <= 1'b0;
        end else begin
            linkSync <= {linkSync[1:0], backLinkUp};
            if (linkSync[1] == linkSync[2])
                linkUp <= linkSync[2];
        end
    end

    always @* begin
        case (regIdx)
            `REG_DATAPATH_CTL: next_rdata = datapathCtl;
            `REG_RSVD_34: next_rdata = rsvd34;
            `REG_PARTNER_CAP: next_rdata = partnerCap;
            `REG_RSVD_36: next_rdata = rsvd36;
            `REG_PARTNER_ADDR: next_rdata = partnerAddr;
            `REG_RSVD_38: next_rdata = rsvd38;
            `REG_TARGET_ZERO: next_rdata = {targetZero, 1'b0};
            `REG_TARGET_ONE: next_rdata = {targetOne, 1'b0};
            `REG_CAP_LOW: next_rdata = capLow;
            `REG_CAP_HIGH: next_rdata = capHigh;
            `REG_ALIAS_ZERO: next_rdata = {aliasZero, 1'b0};
            `REG_ALIAS_ONE: next_rdata = {aliasOne, 1'b0};
            default: next_rdata = 8'h00;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= access;
            if (rdEn)
                wb_dat_o <= {24'h000000, next_rdata};
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            datapathCtl <= `RST_DATAPATH_CTL;
            rsvd34 <= `RST_RSVD;
            rsvd36 <= `RST_RSVD;
            rsvd38 <= `RST_RSVD;
            targetZero <= 7'h00;
            targetOne <= 7'h00;
            aliasZero <= 7'h00;
            aliasOne <= 7'h00;
        end else if (wrEn) begin
            case (regIdx)
                `REG_DATAPATH_CTL: datapathCtl <= wrByte;
                `REG_RSVD_34: rsvd34 <= wrByte;
                `REG_RSVD_36: rsvd36 <= wrByte;
                `REG_RSVD_38: rsvd38 <= wrByte;
                `REG_TARGET_ZERO: targetZero <= wrByte[7:1];
                `REG_TARGET_ONE: targetOne <= wrByte[7:1];
                `REG_ALIAS_ZERO: aliasZero <= wrByte[7:1];
                `REG_ALIAS_ONE: aliasOne <= wrByte[7:1];
                default: ;
            endcase
        end
    end

    // capability byte and both extension registers share one freeze; a software write lands last
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            partnerCap <= `RST_PARTNER_CAP;
            capLow <= 8'h00;
            capHigh <= 8'h00;
        end else begin
            if (capAutoLoad) begin
                partnerCap[`SELFTEST_BIT] <= capLoadSelftest;
                partnerCap[`MULTIPORT_BIT] <= capLoadMultiport;
                partnerCap[3:0] <= capLoadPort;
                capLow <= capLoadExtra[7:0];
                capHigh <= capLoadExtra[15:8];
            end
            if (regHit(wrEn, regIdx, `REG_PARTNER_CAP))
                partnerCap <= wrByte;
            if (regHit(wrEn, regIdx, `REG_CAP_LOW))
                capLow <= wrByte;
            if (regHit(wrEn, regIdx, `REG_CAP_HIGH))
                capHigh <= wrByte;
        end
    end

    // address freeze gates only the back-channel load, never software
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            partnerAddr <= 8'h00;
        else if (regHit(wrEn, regIdx, `REG_PARTNER_ADDR))
            partnerAddr <= wrByte;
        else if (addrAutoLoad)
            partnerAddr[7:1] <= addrLoadValue;
    end

    // address byte remap; zero alias never matches so an unset entry stays idle
    always @* begin
        next_i2c = i2cInByte;
        next_remap = 1'b0;
        if (i2cInFirst) begin
            if (entryHit(aliasZero, i2cInByte[7:1])) begin
                next_i2c = {targetZero, i2cInByte[0]};
                next_remap = 1'b1;
            end else if (entryHit(aliasOne, i2cInByte[7:1])) begin
                next_i2c = {targetOne, i2cInByte[0]};
                next_remap = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            i2cOutValid <= 1'b0;
            i2cOutByte <= 8'h00;
            i2cOutFirst <= 1'b0;
            i2cOutRemapped <= 1'b0;
        end else begin
            i2cOutValid <= i2cInValid;
            i2cOutFirst <= i2cInValid && i2cInFirst;
            i2cOutRemapped <= i2cInValid && next_remap;
            if (i2cInValid)
                i2cOutByte <= next_i2c;
        end
    end

    assign gpioSel = gpioMask(datapathCtl[1:0]);

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gpioFwdEnable <= 4'h0;
            gpioFwdData <= 4'h0;
        end else begin
            gpioFwdEnable <= gpioSel;
            gpioFwdData <= gpioIn & gpioSel;
        end
    end

    align_crc_gen crcGen (
        .clk(clk),
        .arst_n(arst_n),
        .crcEnable(datapathCtl[`CRC_EN_BIT]),
        .seqStart(alignStart),
        .seqValid(alignValid),
        .seqByte(alignByte),
        .outValid(alignValidOut),
        .outByte(alignByteOut),
        .outIsCrc(alignCrcOut)
    );

    // extra stage keeps every top output on a local flip-flop
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alignOutValid <= 1'b0;
            alignOutByte <= 8'h00;
            alignOutIsCrc <= 1'b0;
        end else begin
            alignOutValid <= alignValidOut;
            alignOutByte <= alignByteOut;
            alignOutIsCrc <= alignCrcOut;
        end
    end
endmodule
`default_nettype wire

// ===== core/link_partner_defs.vh
`ifndef LINK_PARTNER_DEFS_VH
`define LINK_PARTNER_DEFS_VH

// register indices; byte address is four times the index
`define REG_DATAPATH_CTL 8'h33
`define REG_RSVD_34 8'h34
`define REG_PARTNER_CAP 8'h35
`define REG_RSVD_36 8'h36
`define REG_PARTNER_ADDR 8'h37
`define REG_RSVD_38 8'h38
`define REG_TARGET_ZERO 8'h39
`define REG_TARGET_ONE 8'h3a
// extra registers of this block
`define REG_CAP_LOW 8'h1e
`define REG_CAP_HIGH 8'h1f
`define REG_ALIAS_ZERO 8'h40
`define REG_ALIAS_ONE 8'h41

// field positions
`define CRC_EN_BIT 2
`define CAP_FREEZE_BIT 7
`define SELFTEST_BIT 5
`define MULTIPORT_BIT 4
`define ADDR_FREEZE_BIT 0

// reset values
`define RST_DATAPATH_CTL 8'h04
`define RST_PARTNER_CAP 8'h00
`define RST_RSVD 8'h00
`define RST_TARGET 8'h00

// alignment sequence: crc over 8 bytes, sent as byte 9
`define ALIGN_DATA_BYTES 4'h8
`define ALIGN_LAST_IDX 4'h7
`define CRC_INIT 8'hff
`define CRC_POLY 8'h07

`endif

// ===== test/deser_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module deser_partner_model (
    input wire logic clk,
    output logic backLinkUp,
    output logic capLoadValid,
    output logic capLoadSelftest,
    output logic capLoadMultiport,
    output logic [3:0] capLoadPort,
    output logic [15:0] capLoadExtra,
    output logic addrLoadValid,
    output logic [6:0] addrLoadValue
);
    initial begin
        {backLinkUp, capLoadValid, addrLoadValid, capLoadSelftest, capLoadMultiport} = 5'h0;
        {capLoadPort, capLoadExtra, addrLoadValue} = 27'h0;
    end
    task automatic raiseLink();
        @(posedge clk);
        backLinkUp <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
    // idle fields carry the inverse so a stale value never looks like a load
    task automatic sendCaps(input logic st, input logic mp, input logic [3:0] port, input logic [15:0] ext);
        @(posedge clk);
        capLoadValid <= 1'b1;
        {capLoadSelftest, capLoadMultiport, capLoadPort, capLoadExtra} <= {st, mp, port, ext};
        @(posedge clk);
        capLoadValid <= 1'b0;
        {capLoadSelftest, capLoadMultiport, capLoadPort, capLoadExtra} <= ~{st, mp, port, ext};
    endtask
    task automatic sendAddr(input logic [6:0] a);
        @(posedge clk);
        addrLoadValid <= 1'b1;
        addrLoadValue <= a;
        @(posedge clk);
        addrLoadValid <= 1'b0;
        addrLoadValue <= ~a;
    endtask
endmodule
`default_nettype wire

// ===== test/link_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module link_regs_checker (
    input wire clk,
    input wire arst_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire i2cInValid,
    input wire [7:0] i2cInByte,
    input wire i2cInFirst,
    input wire i2cOutValid,
    input wire [7:0] i2cOutByte,
    input wire i2cOutRemapped,
    input wire alignStart,
    input wire alignValid,
    input wire alignOutValid,
    input wire alignOutIsCrc,
    input wire [3:0] gpioFwdEnable,
    input wire [3:0] gpioFwdData
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] dataRun;
    logic [1:0] startPipe;
    // bytes of the current sequence seen at the output, restarted by its first byte, saturating
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dataRun <= 4'h0;
            startPipe <= 2'b00;
        end else begin
            startPipe <= {startPipe[0], alignValid && alignStart};
            if (alignOutIsCrc)
                dataRun <= 4'h0;
            else if (alignOutValid && startPipe[1])
                dataRun <= 4'h1;
            else if (alignOutValid && dataRun != 4'hf)
                dataRun <= dataRun + 4'h1;
        end
    end
    sequence s_take; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_pulse; wb_ack_o ##1 !wb_ack_o; endsequence
    property p_ack; s_take |=> s_pulse; endproperty
    a_ack: assert property (p_ack) else $error("ack timing wrong");
    property p_no_ack; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    a_no_ack: assert property (p_no_ack) else $error("stray ack");
    property p_dat; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    a_dat: assert property (p_dat) else $error("upper read bits set");
    property p_i2c_data; i2cInValid && !i2cInFirst |=> i2cOutValid && !i2cOutRemapped && i2cOutByte == $past(i2cInByte); endproperty
    a_i2c_data: assert property (p_i2c_data) else $error("data byte altered");
    property p_i2c_rw; i2cInValid |=> (i2cOutByte & 8'h01) == ($past(i2cInByte) & 8'h01); endproperty
    a_i2c_rw: assert property (p_i2c_rw) else $error("direction bit altered");
    property p_i2c_idle; !i2cInValid |=> !i2cOutValid; endproperty
    a_i2c_idle: assert property (p_i2c_idle) else $error("i2c output without input");
    property p_align_lat; alignValid |-> ##2 alignOutValid; endproperty
    a_align_lat: assert property (p_align_lat) else $error("sequence byte lost");
    property p_crc_ninth; alignOutIsCrc |-> alignOutValid && dataRun == 4'h8; endproperty
    a_crc_ninth: assert property (p_crc_ninth) else $error("crc not ninth byte");
    property p_gpio; gpioFwdEnable inside {4'h0, 4'h1, 4'h3, 4'hf} && (gpioFwdData & ~gpioFwdEnable) == 4'h0; endproperty
    a_gpio: assert property (p_gpio) else $error("bad gpio mask");
endmodule
bind link_partner_config_regs link_regs_checker u_chk (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .i2cInValid(i2cInValid),
    .i2cInByte(i2cInByte), .i2cInFirst(i2cInFirst), .i2cOutValid(i2cOutValid), .i2cOutByte(i2cOutByte),
    .i2cOutRemapped(i2cOutRemapped), .alignStart(alignStart), .alignValid(alignValid), .alignOutValid(alignOutValid),
    .alignOutIsCrc(alignOutIsCrc), .gpioFwdEnable(gpioFwdEnable), .gpioFwdData(gpioFwdData));
`default_nettype wire

// ===== test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk, arst_n, cyc, stb, we, ack, iv, ifst, iov, iorm, ast, av, aov, aoc;
    logic linkUp, capV, capSt, capMp, addrV, iofst;
    logic [9:0] adr;
    logic [3:0] sel, gpioIn, gpioEn, gpioData, capPort;
    logic [31:0] wdat, rdat;
    logic [7:0] ib, iob, ab, aob, got, crcExp, crcSeen;
    logic [15:0] capExtra;
    logic [6:0] addrVal;
    logic [3:0] gpioMask [4] = '{4'h0, 4'h1, 4'h3, 4'hf};
    integer num_errors = 0, n_checks = 0, crcCount = 0;
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    link_partner_config_regs u_dut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .backLinkUp(linkUp),
        .capLoadValid(capV), .capLoadSelftest(capSt), .capLoadMultiport(capMp), .capLoadPort(capPort),
        .capLoadExtra(capExtra), .addrLoadValid(addrV), .addrLoadValue(addrVal), .i2cInValid(iv),
        .i2cInByte(ib), .i2cInFirst(ifst), .i2cOutValid(iov), .i2cOutByte(iob), .i2cOutFirst(iofst),
        .i2cOutRemapped(iorm), .alignStart(ast), .alignValid(av), .alignByte(ab), .alignOutValid(aov),
        .alignOutByte(aob), .alignOutIsCrc(aoc), .gpioIn(gpioIn), .gpioFwdEnable(gpioEn), .gpioFwdData(gpioData));
    deser_partner_model u_partner (.clk(clk), .backLinkUp(linkUp), .capLoadValid(capV), .capLoadSelftest(capSt),
        .capLoadMultiport(capMp), .capLoadPort(capPort), .capLoadExtra(capExtra), .addrLoadValid(addrV),
        .addrLoadValue(addrVal));
    always @(posedge clk) begin
        if (aov && aoc) begin
            crcSeen <= aob;
            crcCount <= crcCount + 1;
        end
    end
    task automatic summarize();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [7:0] exp, input logic [7:0] act);
        n_checks++;
        if (act !== exp) begin
            num_errors++;
            $display("Error t=%0t exp=%h got=%h", $time, exp, act);
        end
    endtask
    task automatic xfer(input logic [7:0] idx, input logic w, input logic [7:0] d);
        integer n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, sel} <= {2'b11, w, 4'hf};
        adr <= {idx, 2'b00};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        got = rdat[7:0];
        {cyc, stb} <= 2'b00;
        if (ack !== 1'b1) begin
            num_errors++;
            summarize();
        end
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] e);
        xfer(idx, 1'b0, 8'h00);
        chk(e, got);
    endtask
    task automatic i2c(input logic f, input logic [7:0] b, input logic [7:0] e, input logic r);
        @(posedge clk);
        {iv, ifst, ib} <= {1'b1, f, b};
        @(posedge clk);
        {iv, ib} <= {1'b0, ~b};
        @(negedge clk);
        chk({e[7:1], r}, {iob[7:1], iorm});
        chk(e, iob);
        chk({6'h00, 1'b1, f}, {6'h00, iov, iofst});
    endtask
    task automatic alignSeq(input logic [7:0] seed);
        crcExp = 8'hff;
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            {av, ast, ab} <= {1'b1, i == 0, seed + i[7:0]};
            crcExp = crcExp ^ (seed + i[7:0]);
            for (int k = 0; k < 8; k++)
                crcExp = {crcExp[6:0], 1'b0} ^ (crcExp[7] ? 8'h07 : 8'h00);
        end
        @(posedge clk);
        {av, ast} <= 2'b00;
        repeat (4) @(posedge clk);
    endtask
    initial begin
        {cyc, stb, we, iv, ifst, ast, av, arst_n} = 8'h0;
        {adr, sel, wdat, ib, ab} = 62'h0;
        gpioIn = 4'h6;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        rd(8'h33, 8'h04);
        rd(8'h35, 8'h00);
        xfer(8'h50, 1'b1, 8'hff);
        rd(8'h50, 8'h00);
        xfer(8'h39, 1'b1, 8'h21);
        rd(8'h39, 8'h20);
        $display("test reset and map done");
        for (int c = 0; c < 4; c++) begin
            xfer(8'h33, 1'b1, {6'h01, c[1:0]});
            repeat (3) @(negedge clk);
            chk({gpioMask[c], gpioMask[c] & gpioIn}, {gpioEn, gpioData});
        end
        $display("test gpio done");
        u_partner.sendCaps(1'b1, 1'b1, 4'h5, 16'h5a3c);
        rd(8'h35, 8'h00);
        u_partner.raiseLink();
        u_partner.sendCaps(1'b1, 1'b1, 4'h5, 16'h5a3c);
        rd(8'h35, 8'h35);
        rd(8'h1e, 8'h3c);
        rd(8'h1f, 8'h5a);
        u_partner.sendAddr(7'h2a);
        rd(8'h37, 8'h54);
        xfer(8'h35, 1'b1, 8'hb2);
        u_partner.sendCaps(1'b0, 1'b0, 4'h3, 16'hc3a5);
        rd(8'h35, 8'hb2);
        rd(8'h1e, 8'h3c);
        rd(8'h1f, 8'h5a);
        xfer(8'h37, 1'b1, 8'h11);
        u_partner.sendAddr(7'h05);
        rd(8'h37, 8'h11);
        $display("test auto-load done");
        xfer(8'h40, 1'b1, 8'h60);
        xfer(8'h41, 1'b1, 8'h44);
        xfer(8'h3a, 1'b1, 8'h7e);
        i2c(1'b1, 8'h61, 8'h21, 1'b1);
        i2c(1'b1, 8'h60, 8'h20, 1'b1);
        i2c(1'b0, 8'h61, 8'h61, 1'b0);
        i2c(1'b1, 8'h62, 8'h62, 1'b0);
        i2c(1'b1, 8'h45, 8'h7f, 1'b1);
        $display("test remap done");
        alignSeq(8'h10);
        chk(8'h01, crcCount[7:0]);
        chk(crcExp, crcSeen);
        xfer(8'h33, 1'b1, 8'h00);
        alignSeq(8'h80);
        chk(8'h01, crcCount[7:0]);
        $display("test crc done");
        summarize();
    end
endmodule
`default_nettype wire
